// ---- dv/jhb_chk.sv ----
// checker of jhb_seq: bus answers and motion output relations
// assumes bind onto jhb_seq, accelerations left at one count per tick
`timescale 1ns/100ps
module jhb_chk (
    input wire logic pclk, // apb clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic moving, // axis in motion
    input wire logic dir_rev, // direction reverse
    input wire logic [7:0] paddr, // byte address
    input wire logic [31:0] prdata, // read data
    input wire logic [31:0] pos_cmd, // commanded position
    input wire logic [15:0] vel_cmd // speed
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy; psel && penable |-> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready low in access");
    property p_eph; pslverr |-> psel && penable; endproperty
    a_eph: assert property (p_eph) else $error("error outside access");
    property p_emap; psel && penable && paddr > 8'h30 |-> pslverr && prdata == 0; endproperty
    a_emap: assert property (p_emap) else $error("unmapped not refused");
    property p_okmap; psel && penable && paddr <= 8'h30 && paddr[1:0] == 0 |-> !pslverr; endproperty
    a_okmap: assert property (p_okmap) else $error("mapped refused");
    property p_ivel; !moving |-> vel_cmd == 0; endproperty
    a_ivel: assert property (p_ivel) else $error("speed while idle");
    property p_ipos; !moving [*2] |-> $stable(pos_cmd); endproperty
    a_ipos: assert property (p_ipos) else $error("position drifts idle");
    property p_idir; !moving [*2] |-> $stable(dir_rev); endproperty
    a_idir: assert property (p_idir) else $error("direction drifts idle");
    // speed may only climb by the one count per tick set up in the bench
    property p_ramp; moving && $past(moving) |-> vel_cmd <= $past(vel_cmd) + 16'h1; endproperty
    a_ramp: assert property (p_ramp) else $error("speed jump");
    c_mv: cover property ($rose(moving));
    c_err: cover property (pslverr);
    c_rev: cover property (moving && dir_rev);
endmodule

// ---- dv/jhb_stage_model.sv ----
// stage model: limit switches and reference marker seen at the commanded position
// assumes the stage follows pos_cmd exactly; forward switch opens, reverse closes
`timescale 1ns/100ps
module jhb_stage_model
    import jhb_pkg::*;
(
    input wire logic [31:0] pos_cmd, // commanded position
    input wire logic signed [31:0] mark_at, // marker place
    output jhb_stage_s stage_in // switches and marker
);
    localparam int LIM_AT = 3000; // switch places, plus and minus
    // one assignment drives the whole bundle: forward switch breaks, reverse makes
    // marker window of five counts, so a four count tick step cannot jump it
    assign stage_in = {!($signed(pos_cmd) >= LIM_AT), $signed(pos_cmd) <= -LIM_AT,
        $signed(pos_cmd) >= mark_at - 2 && $signed(pos_cmd) <= mark_at + 2};
endmodule

// ---- dv/test_jhb_seq.sv ----
// bench of jhb_seq: apb master, stage model, jog and home runs
// assumes a four cycle profile tick and 2000 counts per mm
`timescale 1ns/100ps
module test_jhb_seq;
    import jhb_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic dir_rev, moving, homed;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, pos_cmd, rd;
    logic [15:0] vel_cmd;
    jhb_stage_s stage_in;
    jhb_panel_s panel_in = '0;
    int failures = 0, num_checks = 0, cyc = 0, mark_at = 9999, pn, px, pl, vx, p0, d, s, v, z;
    jhb_seq #(.TICK_CYC(4)) dut (.*);
    jhb_stage_model stage (.*);
    initial forever #50 pclk = ~pclk;
    always @(posedge pclk) begin // extremes while moving, hang limit
        cyc++;
        if (moving === 1'b1) begin
            pl = $signed(pos_cmd); pn = pl < pn ? pl : pn; px = pl > px ? pl : px;
            vx = vel_cmd > vx ? vel_cmd : vx;
        end
        if (cyc == 40000) begin failures++; print_verdict(); end
    end
    function int cnt(int um); return um * 2000 / 1000; endfunction
    task print_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, e);
        num_checks++;
        if (g !== e) begin failures++; $display("BAD %0t got %0h want %0h", $time, g, e); end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] dat); // one transfer
        @(posedge pclk); psel <= 1; pwrite <= w; paddr <= a; pwdata <= dat;
        @(posedge pclk); penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1); // answer taken at the rising edge
        rd = prdata; err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task idle_wait; repeat (4) @(posedge pclk); do @(negedge pclk); while (moving !== 1'b0); endtask
    task move_wait; do @(negedge pclk); while (moving !== 1'b1); endtask
    initial begin
        void'($urandom(35461));
        repeat (6) @(posedge pclk);
        presetn <= 1;
        apb(0, JHB_CTRL_OFS, 0); chk(rd, JHB_CTRL_RST);
        apb(0, 8'h40, 0); chk(err, 1);
        apb(1, JHB_CPMM_OFS, 0); apb(0, JHB_CPMM_OFS, 0); chk(rd, JHB_CPMM_MIN);
        apb(1, JHB_CPMM_OFS, 32'h3000); apb(0, JHB_CPMM_OFS, 0); chk(rd, JHB_CPMM_MAX);
        s = 20 + $urandom % 40;
        apb(1, JHB_CPMM_OFS, 32'h7d0); apb(1, JHB_STEP_OFS, s); apb(1, JHB_LIM_OFS, 32'h4);
        for (int h = 1; h < 700; h += 600) begin // short press, then long hold
            p0 = pos_cmd;
            @(posedge pclk); panel_in.jog_fwd <= 1; move_wait();
            repeat (h) @(posedge pclk); panel_in.jog_fwd <= 0; idle_wait();
            d = pos_cmd - p0;
            chk(d % cnt(s), 0);
            chk(h > 1 ? d >= 2 * cnt(s) : d == cnt(s), 1);
        end
        for (int b = 20; b >= 0; b -= 20) begin // reverse step with and without backlash
            apb(1, JHB_BKL_OFS, b); p0 = pos_cmd; pn = p0;
            apb(1, JHB_CTRL_OFS, 32'h202); move_wait(); apb(1, JHB_CTRL_OFS, 32'h2); idle_wait();
            chk(pos_cmd, p0 - cnt(s));
            chk(pn, p0 - cnt(s) - cnt(b));
        end
        v = 4 + $urandom % 8; apb(1, JHB_JVEL_OFS, v);
        for (int pr = 0; pr < 2; pr++) begin // immediate, then profiled stop
            vx = 0; apb(1, JHB_CTRL_OFS, 32'h101 | pr << 1); repeat (120) @(posedge pclk);
            chk(vx, v);
            // profiled: a reverse asked during the ramp down must wait for rest
            apb(1, JHB_CTRL_OFS, 32'h1 | pr << 1 | pr << 9); repeat (4) @(negedge pclk);
            chk(moving, pr);
            chk(dir_rev, 0);
            if (pr) begin // pending reverse starts after rest, then stop it at once
                do @(negedge pclk); while (dir_rev !== 1'b1);
                apb(1, JHB_CTRL_OFS, 32'h1);
            end
            idle_wait();
        end
        mark_at = $signed(pos_cmd) + 200; apb(1, JHB_CTRL_OFS, 32'h412); idle_wait();
        chk(homed, 1); chk(pos_cmd, 0);
        mark_at = -50; px = 0; vx = 0; apb(1, JHB_CTRL_OFS, 32'h412); idle_wait();
        chk(px >= 3000, 1); chk(pos_cmd, 0);
        chk(vx <= JHB_HVEL_RST, 1);
        z = $urandom % 50; pn = 0; apb(1, JHB_ZOFS_OFS, z); apb(1, JHB_CTRL_OFS, 32'h40e);
        idle_wait();
        chk(pn <= -3000, 1); chk(pl, pn + cnt(z));
        print_verdict();
    end
endmodule
bind jhb_seq jhb_chk u_chk (.*);

// ---- rtl/jhb_pkg.sv ----
// jog, home and backlash sequencer: shared constants, register map and types
// assumes a 32-bit apb slave at 10 mhz with all registers one aligned word each
package jhb_pkg;

    // ***********************************************
    // register byte offsets
    // ***********************************************
    localparam logic [7:0] JHB_CTRL_OFS = 8'h00; // mode, stop, home options, commands
    localparam logic [7:0] JHB_STEP_OFS = 8'h04; // jog step size, 1/1000 mm
    localparam logic [7:0] JHB_JVEL_OFS = 8'h08; // jog max velocity, counts per tick
    localparam logic [7:0] JHB_JACC_OFS = 8'h0c; // jog acceleration, counts per tick per tick
    localparam logic [7:0] JHB_MACC_OFS = 8'h10; // normal move acceleration
    localparam logic [7:0] JHB_HVEL_OFS = 8'h14; // homing velocity cap
    localparam logic [7:0] JHB_BKL_OFS = 8'h18; // backlash distance, 1/1000 mm
    localparam logic [7:0] JHB_ZOFS_OFS = 8'h1c; // home zero offset, 1/1000 mm
    localparam logic [7:0] JHB_CPMM_OFS = 8'h20; // encoder counts per mm
    localparam logic [7:0] JHB_LIM_OFS = 8'h24; // limit switch senses
    localparam logic [7:0] JHB_STAT_OFS = 8'h28; // state, flags (read only)
    localparam logic [7:0] JHB_POS_OFS = 8'h2c; // commanded position (read only)
    localparam logic [7:0] JHB_MVEL_OFS = 8'h30; // normal move minimum velocity

    // ***********************************************
    // ctrl field positions
    // ***********************************************
    localparam int JHB_CTRL_CONT = 0; // 1: continuous jog, 0: step jog
    localparam int JHB_CTRL_PROF = 1; // 1: profiled stop, 0: immediate
    localparam int JHB_CTRL_HREV = 2; // homing direction reverse
    localparam int JHB_CTRL_HSWR = 3; // home switch is the reverse one
    localparam int JHB_CTRL_HMRK = 4; // home on encoder marker
    localparam int JHB_CTRL_JFWD = 8; // software jog forward, level
    localparam int JHB_CTRL_JREV = 9; // software jog reverse, level
    localparam int JHB_CTRL_HOME = 10; // software home request, self clearing
    localparam int JHB_CTRL_STOP = 11; // software stop, self clearing

    // ***********************************************
    // reset values and limits
    // ***********************************************
    localparam logic [31:0] JHB_CTRL_RST = 32'h0000_0002;
    localparam logic [31:0] JHB_STEP_RST = 32'h0000_0032; // 0.05 mm
    localparam logic [31:0] JHB_JVEL_RST = 32'h0000_0010;
    localparam logic [31:0] JHB_JACC_RST = 32'h0000_0001;
    localparam logic [31:0] JHB_MACC_RST = 32'h0000_0001;
    localparam logic [31:0] JHB_HVEL_RST = 32'h0000_0004;
    localparam logic [31:0] JHB_MVEL_RST = 32'h0000_0001;
    localparam logic [31:0] JHB_CPMM_RST = 32'h0000_03e8;
    localparam logic [31:0] JHB_CPMM_MIN = 32'h0000_0001;
    localparam logic [31:0] JHB_CPMM_MAX = 32'h0000_2710; // 10,000
    localparam logic [31:0] JHB_MILLI = 32'h0000_03e8; // distances are held in 1/1000 mm

    // ***********************************************
    // timing
    // ***********************************************
    localparam int JHB_CLK_HZ = 10_000_000;
    localparam int JHB_TICK_US = 100; // profile update period
    localparam int JHB_TICK_CYC = JHB_CLK_HZ / 1_000_000 * JHB_TICK_US;

    // ***********************************************
    // limit switch senses
    // ***********************************************
    typedef enum logic [1:0] {
        JHB_SW_MAKES = 2'h0, // closes on contact
        JHB_SW_BREAKS = 2'h1, // opens on contact
        JHB_SW_IGNORE = 2'h2, // missing or ignored
        JHB_SW_NA = 2'h3 // not applicable
    } jhb_sense_e;

    // sequencer states
    typedef enum logic [3:0] {
        JHB_IDLE, JHB_STEPMV, JHB_CONT, JHB_BKLRET, JHB_DECEL,
        JHB_HSRCH, JHB_HMREV, JHB_HOFS
    } jhb_state_e;

    // motor stage inputs carried together
    typedef struct packed {
        logic fwd_lim; // forward limit switch raw
        logic rev_lim; // reverse limit switch raw
        logic marker; // encoder reference marker raw
    } jhb_stage_s;

    // front panel buttons carried together
    typedef struct packed {
        logic jog_fwd; // jog forward button
        logic jog_rev; // jog reverse button
        logic home; // home button
    } jhb_panel_s;

endpackage

// ---- rtl/jhb_scale.sv ----
// jog, home and backlash sequencer: distance to encoder count scaler
// assumes distances in 1/1000 mm and an already clamped counts-per-mm value
`timescale 1ns/100ps

module jhb_scale
    import jhb_pkg::*;
(
    input wire logic [31:0] dist_um, // distance in 1/1000 mm
    input wire logic [31:0] cpmm, // counts per mm, 1 to 10,000
    output logic [31:0] counts // distance in encoder counts
);
    // ***********************************************
    // scaling
    // ***********************************************
    logic [63:0] prod; // wide product keeps the full range exact

    // plain combinational divide; settings change rarely, so area is the trade
    always_comb begin
        prod = {32'h0, dist_um} * {32'h0, cpmm};
        counts = 32'((prod + 64'(JHB_MILLI / 2)) / 64'(JHB_MILLI));
    end
endmodule

// ---- rtl/jhb_seq.sv ----
// jog, home and backlash sequencer for one servo axis
// assumes an apb master on pclk and a stage whose switches and marker are asynchronous
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps

module jhb_seq
    import jhb_pkg::*;
#(
    parameter int TICK_CYC = JHB_TICK_CYC // cycles per profile update
) (
    input wire logic pclk, // apb clock, 10 mhz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire jhb_stage_s stage_in, // stage switches and marker
    input wire jhb_panel_s panel_in, // front panel buttons
    output logic [31:0] pos_cmd, // commanded position, counts
    output logic [15:0] vel_cmd, // commanded speed magnitude
    output logic dir_rev, // commanded direction reverse
    output logic moving, // axis in motion
    output logic homed // home sequence finished
);
    // ***********************************************
    // input synchronisers
    // ***********************************************
    logic [5:0] sync1_reg; // first stage, read only by the second
    logic [5:0] sync2_reg; // second stage, safe to use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 6'h00;
            sync2_reg <= 6'h00;
        end else begin
            sync1_reg <= {stage_in, panel_in};
            sync2_reg <= sync1_reg;
        end
    end

    // ***********************************************
    // registers
    // ***********************************************
    logic [31:0] ctrl_reg, ctrl_next; // mode bits and commands
    logic [31:0] step_reg, step_next; // step size
    logic [31:0] jvel_reg, jvel_next; // jog velocity
    logic [31:0] jacc_reg, jacc_next; // jog acceleration
    logic [31:0] macc_reg, macc_next; // move acceleration
    logic [31:0] mvel_reg, mvel_next; // move minimum velocity
    logic [31:0] hvel_reg, hvel_next; // homing velocity
    logic [31:0] bkl_reg, bkl_next; // backlash
    logic [31:0] zofs_reg, zofs_next; // zero offset
    logic [31:0] cpmm_reg, cpmm_next; // counts per mm
    logic [3:0] lim_reg, lim_next; // switch senses, rev [1:0], fwd [3:2]
    logic wr, rd_ok; // write strobe, address decoded
    logic home_clr, stop_clr; // sequencer took the one-shot command

    assign wr = psel && penable && pwrite;
    assign pready = 1'b1; // zero wait states
    assign pslverr = psel && penable && !rd_ok;

    // register write decode
    always_comb begin
        ctrl_next = ctrl_reg;
        step_next = step_reg;
        jvel_next = jvel_reg;
        jacc_next = jacc_reg;
        macc_next = macc_reg;
        mvel_next = mvel_reg;
        hvel_next = hvel_reg;
        bkl_next = bkl_reg;
        zofs_next = zofs_reg;
        cpmm_next = cpmm_reg;
        lim_next = lim_reg;
        // one-shot commands clear when taken; a new write in that cycle wins
        if (home_clr) ctrl_next[JHB_CTRL_HOME] = 1'b0;
        if (stop_clr) ctrl_next[JHB_CTRL_STOP] = 1'b0;
        if (wr) begin
            case (paddr)
                JHB_CTRL_OFS: ctrl_next = pwdata & 32'h0000_0f1f;
                JHB_STEP_OFS: step_next = pwdata;
                JHB_JVEL_OFS: jvel_next = pwdata;
                JHB_JACC_OFS: jacc_next = pwdata;
                JHB_MACC_OFS: macc_next = pwdata;
                JHB_MVEL_OFS: mvel_next = pwdata;
                JHB_HVEL_OFS: hvel_next = pwdata;
                JHB_BKL_OFS: bkl_next = pwdata;
                JHB_ZOFS_OFS: zofs_next = pwdata;
                // out-of-range scale is clamped into its legal span
                JHB_CPMM_OFS: cpmm_next = (pwdata < JHB_CPMM_MIN) ? JHB_CPMM_MIN :
                    (pwdata > JHB_CPMM_MAX) ? JHB_CPMM_MAX : pwdata;
                JHB_LIM_OFS: lim_next = pwdata[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= JHB_CTRL_RST;
            step_reg <= JHB_STEP_RST;
            jvel_reg <= JHB_JVEL_RST;
            jacc_reg <= JHB_JACC_RST;
            macc_reg <= JHB_MACC_RST;
            mvel_reg <= JHB_MVEL_RST;
            hvel_reg <= JHB_HVEL_RST;
            bkl_reg <= 32'h0;
            zofs_reg <= 32'h0;
            cpmm_reg <= JHB_CPMM_RST;
            lim_reg <= 4'h0;
        end else begin
            ctrl_reg <= ctrl_next;
            step_reg <= step_next;
            jvel_reg <= jvel_next;
            jacc_reg <= jacc_next;
            macc_reg <= macc_next;
            mvel_reg <= mvel_next;
            hvel_reg <= hvel_next;
            bkl_reg <= bkl_next;
            zofs_reg <= zofs_next;
            cpmm_reg <= cpmm_next;
            lim_reg <= lim_next;
        end
    end

    // ***********************************************
    // distance scaling, one scaler instance per distance setting
    // ***********************************************
    logic [31:0] step_cnt, bkl_cnt, zofs_cnt; // distances in counts
    jhb_scale u_step (.dist_um(step_reg), .cpmm(cpmm_reg), .counts(step_cnt));
    jhb_scale u_bkl (.dist_um(bkl_reg), .cpmm(cpmm_reg), .counts(bkl_cnt));
    jhb_scale u_zofs (.dist_um(zofs_reg), .cpmm(cpmm_reg), .counts(zofs_cnt));

    // ***********************************************
    // limit switch interpretation
    // ***********************************************
    logic fwd_hit, rev_hit, marker_s; // switch contact, marker seen
    function automatic logic sense(input logic raw, input logic [1:0] mode);
        case (jhb_sense_e'(mode))
            JHB_SW_MAKES: sense = raw;
            JHB_SW_BREAKS: sense = !raw;
            default: sense = 1'b0; // ignored or not applicable
        endcase
    endfunction
    assign fwd_hit = sense(sync2_reg[5], lim_reg[3:2]);
    assign rev_hit = sense(sync2_reg[4], lim_reg[1:0]);
    assign marker_s = sync2_reg[3];

    // ***********************************************
    // profile tick divider
    // ***********************************************
    logic [15:0] tdiv_reg, tdiv_next; // tick divider count
    logic tick; // one-cycle profile update enable
    always_comb begin
        tick = (tdiv_reg == 16'(TICK_CYC - 1));
        tdiv_next = tick ? 16'h0 : tdiv_reg + 16'h1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) tdiv_reg <= 16'h0;
        else tdiv_reg <= tdiv_next;
    end

    // ***********************************************
    // sequencer
    // ***********************************************
    jhb_state_e st_reg, st_next; // sequencer state
    logic [31:0] pos_reg, pos_next; // commanded position
    logic [31:0] rem_reg, rem_next; // counts left in current leg
    logic [15:0] vel_reg, vel_next; // present speed
    logic rev_reg, rev_next; // present direction
    logic homed_reg, homed_next; // homed flag
    logic jf, jr, jreq, hreq; // merged requests
    logic [15:0] vmax, acc, vstep; // active limits and step this tick
    logic brake; // must slow to stop within remaining distance

    assign jf = ctrl_reg[JHB_CTRL_JFWD] || sync2_reg[2];
    assign jr = ctrl_reg[JHB_CTRL_JREV] || sync2_reg[1];
    assign jreq = jf ^ jr; // both held means no jog
    assign hreq = ctrl_reg[JHB_CTRL_HOME] || sync2_reg[0];

    always_comb begin
        st_next = st_reg;
        pos_next = pos_reg;
        rem_next = rem_reg;
        vel_next = vel_reg;
        rev_next = rev_reg;
        homed_next = homed_reg;
        home_clr = 1'b0;
        stop_clr = 1'b0;
        // jog legs use jog settings; homing caps at homing velocity
        if (st_reg == JHB_HSRCH || st_reg == JHB_HMREV || st_reg == JHB_HOFS) begin
            vmax = hvel_reg[15:0];
            acc = macc_reg[15:0];
        end else begin
            vmax = jvel_reg[15:0];
            acc = jacc_reg[15:0];
        end
        // distance to stop is about v*v/(2a); brake when remaining is short
        brake = ({48'h0, vel_reg} * {48'h0, vel_reg}) >= ({31'h0, rem_reg, 1'b0} * {48'h0, acc});
        vstep = (vel_reg > rem_reg[15:0] && rem_reg[31:16] == 16'h0) ? rem_reg[15:0] : vel_reg;
        case (st_reg)
            JHB_IDLE: begin
                vel_next = 16'h0;
                stop_clr = ctrl_reg[JHB_CTRL_STOP];
                if (hreq) begin
                    home_clr = 1'b1;
                    homed_next = 1'b0;
                    rev_next = ctrl_reg[JHB_CTRL_HMRK] ? 1'b0 : ctrl_reg[JHB_CTRL_HREV];
                    st_next = JHB_HSRCH;
                end else if (jreq) begin
                    rev_next = jr;
                    if (ctrl_reg[JHB_CTRL_CONT]) begin
                        st_next = JHB_CONT;
                    end else begin
                        // reverse steps run on past by the backlash
                        rem_next = jr ? step_cnt + bkl_cnt : step_cnt;
                        st_next = JHB_STEPMV;
                    end
                end
            end
            JHB_STEPMV, JHB_BKLRET: begin
                if (ctrl_reg[JHB_CTRL_STOP] && !ctrl_reg[JHB_CTRL_PROF]) begin
                    stop_clr = 1'b1;
                    st_next = JHB_IDLE;
                end else if (rem_reg == 32'h0) begin
                    vel_next = 16'h0;
                    if (st_reg == JHB_STEPMV && rev_reg && bkl_cnt != 32'h0) begin
                        rev_next = 1'b0; // come back forward onto target
                        rem_next = bkl_cnt;
                        st_next = JHB_BKLRET;
                    end else begin
                        st_next = JHB_IDLE; // held request starts the next step
                    end
                end else if (tick) begin
                    pos_next = rev_reg ? pos_reg - {16'h0, vstep} : pos_reg + {16'h0, vstep};
                    rem_next = rem_reg - {16'h0, vstep};
                    if (brake) vel_next = (vel_reg > acc) ? vel_reg - acc : 16'h1;
                    else if (vel_reg < vmax) vel_next = (vmax - vel_reg > acc) ? vel_reg + acc : vmax;
                end
            end
            JHB_CONT: begin
                if (!jreq || (jr != rev_reg) || ctrl_reg[JHB_CTRL_STOP]) begin
                    stop_clr = 1'b1;
                    // release starts the chosen stop
                    if (ctrl_reg[JHB_CTRL_PROF]) st_next = JHB_DECEL;
                    else st_next = JHB_IDLE;
                end else if (tick) begin
                    pos_next = rev_reg ? pos_reg - {16'h0, vel_reg} : pos_reg + {16'h0, vel_reg};
                    if (vel_reg < vmax) vel_next = (vmax - vel_reg > acc) ? vel_reg + acc : vmax;
                end
            end
            JHB_DECEL: begin
                // new requests stay pending until the axis is at rest
                if (vel_reg == 16'h0) st_next = JHB_IDLE;
                else if (tick) begin
                    pos_next = rev_reg ? pos_reg - {16'h0, vel_reg} : pos_reg + {16'h0, vel_reg};
                    vel_next = (vel_reg > acc) ? vel_reg - acc : 16'h0;
                end
            end
            JHB_HSRCH, JHB_HMREV: begin
                if (ctrl_reg[JHB_CTRL_STOP]) begin
                    stop_clr = 1'b1;
                    st_next = JHB_IDLE;
                end else if (ctrl_reg[JHB_CTRL_HMRK] && marker_s) begin
                    pos_next = 32'h0; // marker is home
                    homed_next = 1'b1;
                    st_next = JHB_IDLE;
                end else if (ctrl_reg[JHB_CTRL_HMRK] && st_reg == JHB_HSRCH && fwd_hit) begin
                    rev_next = 1'b1; // limit first, search back
                    vel_next = 16'h0;
                    st_next = JHB_HMREV;
                end else if (!ctrl_reg[JHB_CTRL_HMRK] &&
                        (ctrl_reg[JHB_CTRL_HSWR] ? rev_hit : fwd_hit)) begin
                    // back off from the switch by the zero offset
                    rev_next = !ctrl_reg[JHB_CTRL_HSWR];
                    rem_next = zofs_cnt;
                    vel_next = 16'h0;
                    st_next = JHB_HOFS;
                end else if (tick) begin
                    pos_next = rev_reg ? pos_reg - {16'h0, vel_reg} : pos_reg + {16'h0, vel_reg};
                    if (vel_reg < mvel_reg[15:0]) vel_next = mvel_reg[15:0];
                    else if (vel_reg < vmax) vel_next = (vmax - vel_reg > acc) ? vel_reg + acc : vmax;
                    else vel_next = vmax;
                end
            end
            JHB_HOFS: begin
                if (rem_reg == 32'h0) begin
                    pos_next = 32'h0;
                    homed_next = 1'b1;
                    vel_next = 16'h0;
                    st_next = JHB_IDLE;
                end else if (tick) begin
                    pos_next = rev_reg ? pos_reg - {16'h0, vstep} : pos_reg + {16'h0, vstep};
                    rem_next = rem_reg - {16'h0, vstep};
                    if (brake) vel_next = (vel_reg > acc) ? vel_reg - acc : 16'h1;
                    else if (vel_reg < vmax) vel_next = (vmax - vel_reg > acc) ? vel_reg + acc : vmax;
                end
            end
            default: st_next = JHB_IDLE;
        endcase
        // immediate stop: drop speed to zero at once
        if (st_next == JHB_IDLE) vel_next = 16'h0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= JHB_IDLE;
            pos_reg <= 32'h0;
            rem_reg <= 32'h0;
            vel_reg <= 16'h0;
            rev_reg <= 1'b0;
            homed_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            pos_reg <= pos_next;
            rem_reg <= rem_next;
            vel_reg <= vel_next;
            rev_reg <= rev_next;
            homed_reg <= homed_next;
        end
    end

    // ***********************************************
    // outputs and read mux
    // ***********************************************
    assign pos_cmd = pos_reg;
    assign vel_cmd = vel_reg;
    assign dir_rev = rev_reg;
    assign moving = (st_reg != JHB_IDLE);
    assign homed = homed_reg;

    always_comb begin
        rd_ok = 1'b1;
        case (paddr)
            JHB_CTRL_OFS: prdata = ctrl_reg;
            JHB_STEP_OFS: prdata = step_reg;
            JHB_JVEL_OFS: prdata = jvel_reg;
            JHB_JACC_OFS: prdata = jacc_reg;
            JHB_MACC_OFS: prdata = macc_reg;
            JHB_MVEL_OFS: prdata = mvel_reg;
            JHB_HVEL_OFS: prdata = hvel_reg;
            JHB_BKL_OFS: prdata = bkl_reg;
            JHB_ZOFS_OFS: prdata = zofs_reg;
            JHB_CPMM_OFS: prdata = cpmm_reg;
            JHB_LIM_OFS: prdata = {28'h0, lim_reg};
            JHB_STAT_OFS: prdata = {vel_reg, 6'h0, fwd_hit, rev_hit, homed_reg,
                rev_reg, moving, 1'b0, st_reg};
            JHB_POS_OFS: prdata = pos_reg;
            default: begin
                prdata = 32'h0;
                rd_ok = 1'b0; // unmapped: zero data and pslverr
            end
        endcase
    end
endmodule
